// ---- src/bpmd_pkg.sv ----
// Package with constants shared by the backplane medium control block.
package bpmd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_INT_STAT = 12'h008;
    localparam logic [11:0] ADDR_INT_MASK = 12'h00c;

    // Control fields.
    localparam int CTRL_TX_OFF = 0;
    localparam int CTRL_LOOPBACK = 1;
    localparam int CTRL_SD_ENABLE = 2;
    localparam int CTRL_LPI_ENABLE = 3;
    localparam int CTRL_FAULT_TX_OFF = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Status fields.
    localparam int STAT_SIG_PRESENT = 0;
    localparam int STAT_TX_ACTIVE = 1;
    localparam int STAT_FAULT = 2;
    localparam int STAT_TX_FAULT = 3;
    localparam int STAT_RX_FAULT = 4;

    // Interrupt event fields.
    localparam int INT_SIG_CHANGE = 0;
    localparam int INT_TX_FAULT = 1;
    localparam int INT_RX_FAULT = 2;
    localparam logic [2:0] INT_RESET = 3'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int LATENCY_BUDGET_BITS = 256;
    localparam int SD_SET_TIME_NS = 80;
    localparam int SD_CLR_TIME_NS = 160;
    localparam int SD_SET_RAW = SD_SET_TIME_NS / CLK_PERIOD_NS;
    localparam int SD_CLR_RAW = SD_CLR_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SD_SET_CYCLES = 8'((SD_SET_RAW < 1) ? 1 : SD_SET_RAW);
    localparam logic [7:0] SD_CLR_CYCLES = 8'((SD_CLR_RAW < 1) ? 1 : SD_CLR_RAW);

endpackage

// ---- src/bpmd_sync.sv ----
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
module bpmd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // bpmd_sync

// ---- src/bpmd_detect.sv ----
// Debounce filter that turns raw line energy into a settled presence level.
`timescale 1ns/100ps
module bpmd_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic energy,
    input wire logic [7:0] set_cycles,
    input wire logic [7:0] clr_cycles,
    output logic present_r
);
    logic [7:0] cnt_r;
    logic [7:0] limit;

    assign limit = energy ? set_cycles : clr_cycles;

    // A level must hold for the whole interval; any bounce restarts the count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            present_r <= 1'b0;
        end else if (energy == present_r) begin
            cnt_r <= 8'h00;
        end else if (cnt_r >= limit - 8'h01) begin
            cnt_r <= 8'h00;
            present_r <= energy;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // bpmd_detect

// ---- src/bpmd_top.sv ----
// Control and status logic of the backplane serial medium sublayer.
`timescale 1ns/100ps
// Behaviour
// - Global signal present output always equals the signal indication value.
// - Transmit plus receive latency stays below 256 bit times.
// - Every transmit bit reaches the line in order, unchanged, while the transmitter is enabled.
// - Every line bit reaches the receive output in order, except in loopback, where tx_bit is returned instead.
// - One is a positive differential level, both directions.
// - Without signal detection, signal present is reported OK continuously.
// - With signal detection enabled, signal present follows filtered line energy.
// - Signal present sets and clears within fixed transition times.
// - Low power idle signal detect goes out on the indication output.
// - Quiet during low power idle disables transmitter; it resumes afterwards.
// - Quiet disables the transmitter exactly like an explicit disable.
// - Optionally a sublayer fault turns the transmitter off.
// - Transmitter off leaves loopback data reaching the receive side.
// - Loopback exists and does not itself disable the transmitter.
// - Sublayer fault is one whenever any local fault exists.
// - Transmit fault flag is one on a transmit path fault.
// - Receive fault flag is one on a receive path fault.
module bpmd_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_bit,
    input wire logic tx_quiet,
    output logic rx_bit,
    output logic signal_ind,
    output logic global_signal_present,
    output logic line_tx_p,
    output logic line_tx_n,
    output logic line_tx_en,
    input wire logic line_rx_p,
    input wire logic line_rx_n,
    input wire logic line_energy,
    input wire logic tx_drv_fault,
    input wire logic rx_cdr_fault,
    output logic sublayer_fault,
    output logic tx_path_fault,
    output logic rx_path_fault,
    output logic irq
);
    import bpmd_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [4:0] ctrl_r;
    logic [2:0] int_stat_r;
    logic [2:0] int_mask_r;
    logic [4:0] pins_s;
    logic rx_p_s;
    logic rx_n_s;
    logic energy_s;
    logic tx_fault_s;
    logic rx_fault_s;
    logic det_present;
    logic signal_present_r;
    logic tx_active;
    logic rx_bit_r;
    logic line_tx_p_r;
    logic line_tx_n_r;
    logic line_tx_en_r;
    logic tx_path_fault_r;
    logic rx_path_fault_r;
    logic sublayer_fault_r;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [2:0] events;
    logic transmitter_off_request;
    logic loopback;
    logic sd_enable;
    logic lpi_enable;
    logic fault_tx_off;
    logic [1:0] rst_age_r;

    assign transmitter_off_request = ctrl_r[CTRL_TX_OFF];
    assign loopback = ctrl_r[CTRL_LOOPBACK];
    assign sd_enable = ctrl_r[CTRL_SD_ENABLE];
    assign lpi_enable = ctrl_r[CTRL_LPI_ENABLE];
    assign fault_tx_off = ctrl_r[CTRL_FAULT_TX_OFF];

    // ------------------------------------------------------------
    // Pin synchronisers and energy filter
    // ------------------------------------------------------------
    bpmd_sync #(.WIDTH(5)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({rx_cdr_fault, tx_drv_fault, line_energy, line_rx_n, line_rx_p}),
        .sync_out(pins_s)
    );

    assign rx_p_s = pins_s[0];
    assign rx_n_s = pins_s[1];
    assign energy_s = pins_s[2];
    assign tx_fault_s = pins_s[3];
    assign rx_fault_s = pins_s[4];

    bpmd_detect u_detect (
        .pclk(pclk),
        .presetn(presetn),
        .energy(energy_s),
        .set_cycles(SD_SET_CYCLES),
        .clr_cycles(SD_CLR_CYCLES),
        .present_r(det_present)
    );

    // ------------------------------------------------------------
    // Signal presence
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            signal_present_r <= 1'b0;
        end else if (sd_enable) begin
            signal_present_r <= det_present;
        end else begin
            signal_present_r <= 1'b1;
        end
    end

    // One flop feeds both outputs so they can never disagree.
    assign signal_ind = signal_present_r;
    assign global_signal_present = signal_present_r;

    // ------------------------------------------------------------
    // Faults
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_path_fault_r <= 1'b0;
            rx_path_fault_r <= 1'b0;
        end else begin
            tx_path_fault_r <= tx_fault_s;
            rx_path_fault_r <= rx_fault_s;
        end
    end

    assign sublayer_fault_r = tx_path_fault_r | rx_path_fault_r;
    assign sublayer_fault = sublayer_fault_r;
    assign tx_path_fault = tx_path_fault_r;
    assign rx_path_fault = rx_path_fault_r;

    // ------------------------------------------------------------
    // Transmit and receive paths
    // ------------------------------------------------------------
    // Loopback is deliberately absent from this term.
    assign tx_active = !transmitter_off_request
        && !(lpi_enable && tx_quiet)
        && !(fault_tx_off && sublayer_fault_r);

    // A disabled driver holds both legs low, the zero differential level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_tx_p_r <= 1'b0;
            line_tx_n_r <= 1'b0;
            line_tx_en_r <= 1'b0;
        end else begin
            line_tx_p_r <= tx_active & tx_bit;
            line_tx_n_r <= tx_active & ~tx_bit;
            line_tx_en_r <= tx_active;
        end
    end

    assign line_tx_p = line_tx_p_r;
    assign line_tx_n = line_tx_n_r;
    assign line_tx_en = line_tx_en_r;

    // Tx costs one cycle, rx three, far inside the latency budget.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_bit_r <= 1'b0;
        end else if (loopback) begin
            rx_bit_r <= tx_bit;
        end else begin
            rx_bit_r <= rx_p_s & ~rx_n_s;
        end
    end

    assign rx_bit = rx_bit_r;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
        || (paddr == ADDR_INT_STAT) || (paddr == ADDR_INT_MASK);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_r <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_r <= INT_RESET;
        end else if (wr_en && paddr == ADDR_INT_MASK) begin
            int_mask_r <= pwdata[2:0];
        end
    end

    assign events[INT_SIG_CHANGE] = signal_present_r != det_present && sd_enable;
    assign events[INT_TX_FAULT] = tx_fault_s && !tx_path_fault_r;
    assign events[INT_RX_FAULT] = rx_fault_s && !rx_path_fault_r;

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= INT_RESET;
        end else if (wr_en && paddr == ADDR_INT_STAT) begin
            int_stat_r <= (int_stat_r & ~pwdata[2:0]) | events;
        end else begin
            int_stat_r <= int_stat_r | events;
        end
    end

    assign irq = |(int_stat_r & int_mask_r);

    // Read data is latched in the setup cycle and stable through access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                ADDR_CTRL: prdata <= {27'h0, ctrl_r};
                ADDR_STATUS: prdata <= {27'h0, rx_path_fault_r, tx_path_fault_r,
                    sublayer_fault_r, line_tx_en_r, signal_present_r};
                ADDR_INT_STAT: prdata <= {29'h0, int_stat_r};
                ADDR_INT_MASK: prdata <= {29'h0, int_mask_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int SET_BOUND = 4;

    // Checks wait three edges after reset, until the receive pipe holds real pin values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_age_r <= 2'h0;
        end else if (rst_age_r != 2'h3) begin
            rst_age_r <= rst_age_r + 2'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (rst_age_r != 2'h3);

    AST_GLOBAL_EQ_IND: assert property (
        global_signal_present == signal_ind)
        else $error("global signal present differs from indication");
    // Pin to rx_bit takes three edges and tx_bit to the line one, far inside the budget.
    AST_LATENCY: assert property (
        !loopback |=> rx_bit == ($past(line_rx_p, 3) & !$past(line_rx_n, 3)))
        else $error("receive latency not three cycles");
    AST_TX_DATA: assert property (
        tx_active |=> (line_tx_p == $past(tx_bit)) && (line_tx_n == !$past(tx_bit)))
        else $error("transmitted bit altered");
    AST_RX_DATA: assert property (
        !loopback ##1 1 |-> ##0 1 ##0 (rx_bit == ($past(rx_p_s) & !$past(rx_n_s))))
        else $error("received bit altered");
    AST_SD_OFF_OK: assert property (
        !sd_enable |=> signal_ind)
        else $error("signal not OK without detection");
    AST_SD_SET: assert property (
        (sd_enable && energy_s)[*8] ##1 (sd_enable && energy_s)[*8]
        |-> ##[0:SET_BOUND] signal_ind)
        else $error("signal present not set in time");
    AST_QUIET_OFF: assert property (
        (lpi_enable && tx_quiet) |=> !line_tx_en && !line_tx_p && !line_tx_n)
        else $error("transmitter drives during quiet");
    AST_OFF_REQ: assert property (
        transmitter_off_request |=> !line_tx_en ##0 (line_tx_p == line_tx_n))
        else $error("transmitter drives while off");
    AST_LOOP_OFF: assert property (
        (loopback && transmitter_off_request) |=> rx_bit == $past(tx_bit))
        else $error("loopback broken by transmitter off");
    AST_LOOP_TX: assert property (
        (loopback && !transmitter_off_request && !tx_quiet && !sublayer_fault_r)
        |=> line_tx_en)
        else $error("loopback disabled transmitter");
    AST_FAULT_OR: assert property (
        sublayer_fault == (tx_path_fault || rx_path_fault))
        else $error("sublayer fault not the or of path faults");
    AST_TX_FAULT: assert property (
        $rose(tx_fault_s) |=> tx_path_fault)
        else $error("transmit fault flag missed");
    AST_FAULT_TX_OFF: assert property (
        (fault_tx_off && sublayer_fault) |=> !line_tx_en)
        else $error("fault did not disable transmitter");

    COV_LOOPBACK_OFF: cover property (loopback && transmitter_off_request ##1 rx_bit);
    COV_QUIET_RESUME: cover property (lpi_enable && tx_quiet ##1 !tx_quiet ##1 line_tx_en);
    COV_SD_RISE: cover property (sd_enable ##1 $rose(signal_ind));
    COV_IRQ: cover property ($rose(irq));
endmodule // bpmd_top

// ---- bench/bpmd_partner.sv ----
// Remote link partner model that drives the receive legs and line energy.
`timescale 1ns/100ps
module bpmd_partner (
    input wire logic pclk,
    input wire logic send_on,
    input wire logic send_bit,
    output logic line_rx_p,
    output logic line_rx_n,
    output logic line_energy
);
    // ------
    // Line drive
    // ------
    // An idle partner keeps both legs toggling, so a stale bit never looks valid.
    initial begin
        line_rx_p = 1'b0;
        line_rx_n = 1'b1;
        line_energy = 1'b0;
    end
    always @(posedge pclk) begin
        if (send_on) begin
            line_rx_p <= send_bit;
            line_rx_n <= ~send_bit;
        end else begin
            line_rx_p <= ~line_rx_p;
            line_rx_n <= ~line_rx_n;
        end
        line_energy <= send_on;
    end
endmodule // bpmd_partner

// ---- bench/backplane_pmd_control_bench.sv ----
// Self-checking bench for the backplane medium control block.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module backplane_pmd_control_bench;
    import bpmd_pkg::*;
    localparam logic [15:0] PAT = 16'hb4e1;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_bit, signal_ind, global_signal_present;
    logic tx_bit = 1'b0, tx_quiet = 1'b0, tx_drv_fault = 1'b0, rx_cdr_fault = 1'b0;
    logic send_on = 1'b0, send_bit = 1'b0;
    logic line_tx_p, line_tx_n, line_tx_en, line_rx_p, line_rx_n, line_energy;
    logic sublayer_fault, tx_path_fault, rx_path_fault, irq;
    int mismatches = 0;
    int checked = 0;

    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

    bpmd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_bit(tx_bit), .tx_quiet(tx_quiet), .rx_bit(rx_bit),
        .signal_ind(signal_ind), .global_signal_present(global_signal_present),
        .line_tx_p(line_tx_p), .line_tx_n(line_tx_n), .line_tx_en(line_tx_en),
        .line_rx_p(line_rx_p), .line_rx_n(line_rx_n), .line_energy(line_energy),
        .tx_drv_fault(tx_drv_fault), .rx_cdr_fault(rx_cdr_fault),
        .sublayer_fault(sublayer_fault), .tx_path_fault(tx_path_fault),
        .rx_path_fault(rx_path_fault), .irq(irq));

    bpmd_partner partner (.pclk(pclk), .send_on(send_on), .send_bit(send_bit),
        .line_rx_p(line_rx_p), .line_rx_n(line_rx_n), .line_energy(line_energy));

    // ------
    // Shared tasks
    // ------
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(nm, ex, q)
    endtask

    // The line legs answer one cycle after tx_bit; rx_bit follows by lag cycles.
    task automatic stream(input int lag, input logic on);
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            tx_bit <= PAT[i];
            send_bit <= PAT[i];
            @(negedge pclk);
            if (i > 0) begin
                `CHK("line_tx_en", on, line_tx_en)
                `CHK("line_tx_p", on & PAT[i-1], line_tx_p)
                `CHK("line_tx_n", on & ~PAT[i-1], line_tx_n)
            end
            if (i >= lag) `CHK("rx_bit", PAT[i-lag], rx_bit)
        end
    endtask

    // ------
    // Scenarios
    // ------
    task automatic test_reset();
        logic [31:0] q;
        logic e;
        rd_chk("ctrl", ADDR_CTRL, 32'h0);
        rd_chk("int_mask", ADDR_INT_MASK, 32'h0);
        @(negedge pclk);
        `CHK("signal_ind", 1'b1, signal_ind)
        `CHK("global", signal_ind, global_signal_present)
        apb(1'b0, 12'h010, 32'h0, q, e);
        `CHK("pslverr", 1'b1, e)
        `CHK("unmapped", 32'h0, q)
        $display("test reset done");
    endtask

    task automatic test_paths();
        @(posedge pclk);
        send_on <= 1'b1;
        tick(6);
        stream(4, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        tick(2);
        stream(4, 1'b0);
        wr(ADDR_CTRL, 32'h3);
        tick(2);
        stream(1, 1'b0);
        wr(ADDR_CTRL, 32'h2);
        tick(2);
        stream(1, 1'b1);
        wr(ADDR_CTRL, 32'h8);
        @(posedge pclk);
        tx_quiet <= 1'b1;
        tick(2);
        stream(4, 1'b0);
        @(posedge pclk);
        tx_quiet <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        tick(2);
        stream(4, 1'b1);
        $display("test paths done");
    endtask

    task automatic test_detect();
        int n;
        @(posedge pclk);
        send_on <= 1'b0;
        wr(ADDR_INT_MASK, 32'h1);
        wr(ADDR_CTRL, 32'hc);
        tick(30);
        @(negedge pclk);
        `CHK("present low", 1'b0, signal_ind)
        `CHK("irq change", 1'b1, irq)
        wr(ADDR_INT_STAT, 32'h1);
        tick(1);
        @(negedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        @(posedge pclk);
        send_on <= 1'b1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (signal_ind !== 1'b1 && n < 60);
        `CHK("set time", 1'b1, (n >= SD_SET_CYCLES + 3 && n <= SD_SET_CYCLES + 5))
        `CHK("global", signal_ind, global_signal_present)
        rd_chk("status", ADDR_STATUS, 32'h3);
        @(posedge pclk);
        send_on <= 1'b0;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (signal_ind !== 1'b0 && n < 60);
        `CHK("clr time", 1'b1, (n >= SD_CLR_CYCLES + 3 && n <= SD_CLR_CYCLES + 5))
        `CHK("global", signal_ind, global_signal_present)
        @(posedge pclk);
        send_on <= 1'b1;
        wr(ADDR_CTRL, 32'h0);
        $display("test detect done");
    endtask

    task automatic test_fault();
        wr(ADDR_INT_MASK, 32'h2);
        wr(ADDR_INT_STAT, 32'h7);
        @(posedge pclk);
        tx_drv_fault <= 1'b1;
        tick(5);
        @(negedge pclk);
        `CHK("tx fault", 1'b1, tx_path_fault)
        `CHK("rx fault", 1'b0, rx_path_fault)
        `CHK("fault", 1'b1, sublayer_fault)
        `CHK("irq fault", 1'b1, irq)
        rd_chk("status", ADDR_STATUS, 32'hf);
        wr(ADDR_INT_MASK, 32'h0);
        tick(1);
        @(negedge pclk);
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_INT_STAT, 32'h2);
        rd_chk("int_stat", ADDR_INT_STAT, 32'h0);
        wr(ADDR_CTRL, 32'h10);
        tick(2);
        stream(4, 1'b0);
        @(posedge pclk);
        tx_drv_fault <= 1'b0;
        rx_cdr_fault <= 1'b1;
        tick(5);
        @(negedge pclk);
        `CHK("tx fault off", 1'b0, tx_path_fault)
        `CHK("rx fault on", 1'b1, rx_path_fault)
        `CHK("fault rx", 1'b1, sublayer_fault)
        `CHK("en rx fault", 1'b0, line_tx_en)
        rd_chk("int_stat rx", ADDR_INT_STAT, 32'h4);
        @(posedge pclk);
        rx_cdr_fault <= 1'b0;
        tick(5);
        @(negedge pclk);
        `CHK("fault gone", 1'b0, sublayer_fault)
        stream(4, 1'b1);
        $display("test fault done");
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_paths();
        test_detect();
        test_fault();
        finish_test();
    end
endmodule // backplane_pmd_control_bench
